// ### sbst_pkg.sv
// package: constants and types for the boundary scan test access port
package sbst_pkg;
	localparam int IR_WIDTH = 3;
	localparam int ID_WIDTH = 32;
	localparam int RESET_TMS_EDGES = 5;
	localparam logic [2:0] INS_EXTEST = 3'h0;
	localparam logic [2:0] INS_IDCODE = 3'h1;
	localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [2:0] INS_RESERVED_BYPASS_CODE_A = 3'h3;
	localparam logic [2:0] INS_SAMPLE_PRELOAD = 3'h4;
	localparam logic [2:0] INS_PRIVATE = 3'h5;
	localparam logic [2:0] INS_RESERVED_BYPASS_CODE_B = 3'h6;
	localparam logic [2:0] INS_BYPASS = 3'h7;
	localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
	localparam logic [2:0] IR_RESET_VALUE = INS_IDCODE;
	// arbitrary identification code, not of any real part
	localparam logic [31:0] ID_CODE_DEFAULT = 32'h0000_0A5B;
	typedef enum logic [15:0] {
		ST_RESET      = 16'h0001,
		ST_IDLE       = 16'h0002,
		ST_SEL_DR     = 16'h0004,
		ST_CAPTURE_DR = 16'h0008,
		ST_SHIFT_DR   = 16'h0010,
		ST_EXIT1_DR   = 16'h0020,
		ST_PAUSE_DR   = 16'h0040,
		ST_EXIT2_DR   = 16'h0080,
		ST_UPDATE_DR  = 16'h0100,
		ST_SEL_IR     = 16'h0200,
		ST_CAPTURE_IR = 16'h0400,
		ST_SHIFT_IR   = 16'h0800,
		ST_EXIT1_IR   = 16'h1000,
		ST_PAUSE_IR   = 16'h2000,
		ST_EXIT2_IR   = 16'h4000,
		ST_UPDATE_IR  = 16'h8000
	} sbst_state_t;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} sbst_pins_t;
	typedef struct packed {
		logic rise;
		logic fall;
		logic tms;
		logic tdi;
	} sbst_edge_t;
endpackage

// ### sbst_sync.sv
// synchroniser and edge finder for the test pins
`timescale 1ns/100ps
`default_nettype none
module sbst_sync (
	input  wire logic               clock_i,
	input  wire logic               reset_n_i,
	input  wire sbst_pkg::sbst_pins_t pins_i,
	output var  sbst_pkg::sbst_edge_t edge_o
);
	sbst_pkg::sbst_pins_t meta;
	sbst_pkg::sbst_pins_t sync;
	logic                 tck_prev;
	// reset to one: floating pins read as high
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			meta     <= 3'h7;
			sync     <= 3'h7;
			tck_prev <= 1'h1;
		end else begin
			meta     <= pins_i;
			sync     <= meta;
			tck_prev <= sync.tck;
		end
	end
	always_comb begin
		edge_o.rise = sync.tck & ~tck_prev;
		edge_o.fall = ~sync.tck & tck_prev;
		edge_o.tms  = sync.tms;
		edge_o.tdi  = sync.tdi;
	end
endmodule // sbst_sync
`default_nettype wire

// ### sbst_tap.sv
// boundary scan test access port top
// Functional notes
// - sample tms/tdi on test clock rise, change tdo on fall only.
// - undriven mode-select counts as logic one.
// - undriven serial input shifts in as logic one.
// - five rising edges with tms high reach test-logic-reset.
// - reset at power-up; idle unless test clock toggles.
// - instruction register is 3 bits, shifted only when selected.
// - instruction resets to identification code on reset state.
// - bypass is one flip-flop between serial input and output.
// - boundary register captures pins, then shifts toward output.
// - boundary positions without pin hold logic one.
// - boundary register selected for extest, sample-z, sample/preload.
// - identification instruction captures fixed 32-bit code, then shifts it.
// - identification bit 0 leaves first.
// - capture-ir loads 01 into the two low bits.
// - shift-ir shifts new instruction in, old contents out, lsb first.
// - new instruction acts only after update-ir.
// - exactly one register between serial input and output.
// - serial output active only in states that need it.
// - decode 000 extest 001 id 010 sample-z 100 preload, others bypass.
// - sample-z floats memory outputs and selects boundary register.
`timescale 1ns/100ps
`default_nettype none
module sbst_tap #(
	parameter int               BSR_PINS  = 8,
	parameter int               BSR_SPARE = 2,
	parameter logic [31:0]      ID_CODE   = sbst_pkg::ID_CODE_DEFAULT
) (
	input  wire logic                CLOCK_I,
	input  wire logic                RESET_N_I,
	input  wire logic                TCK_I,
	input  wire logic                TMS_I,
	input  wire logic                TDI_I,
	input  wire logic [BSR_PINS-1:0] PIN_LEVEL_I,
	output logic                     TDO_O,
	output logic                     TDO_OE_O,
	output logic                     OUTPUTS_FLOAT_O,
	output logic                     EXTEST_DRIVE_O,
	output logic [BSR_PINS-1:0]      EXTEST_LEVEL_O,
	output logic [2:0]               INSTRUCTION_O
);
	localparam int BSR_LEN = BSR_PINS + BSR_SPARE;
	// a spare count of zero would leave an empty replication
	if (BSR_PINS < 1 || BSR_SPARE < 1 || BSR_LEN > 1024) begin : g_bad_size
		$error("boundary register size out of range");
	end

	sbst_pkg::sbst_pins_t  pins;
	sbst_pkg::sbst_edge_t  ev;
	sbst_pkg::sbst_state_t state;
	sbst_pkg::sbst_state_t next_state;
	logic [2:0]            ir_shift;
	logic [2:0]            ir_active;
	logic                  bypass_ff;
	logic [BSR_LEN-1:0]    bsr;
	logic [31:0]           id_reg;
	logic                  serial_bit;
	logic                  next_oe;
	logic [BSR_PINS-1:0]   pin_meta;
	logic [BSR_PINS-1:0]   pin_sync;

	assign pins = '{tck: TCK_I, tms: TMS_I, tdi: TDI_I};

	// pins pass two flops; reset value one stands for a floating pin
	sbst_sync u_sync (
		.clock_i   (CLOCK_I),
		.reset_n_i (RESET_N_I),
		.pins_i    (pins),
		.edge_o    (ev)
	);

	// memory pin levels pass two flops before capture
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= PIN_LEVEL_I;
			pin_sync <= pin_meta;
		end
	end

	function automatic logic sel_bsr(input logic [2:0] ins);
		sel_bsr = (ins == sbst_pkg::INS_EXTEST) || (ins == sbst_pkg::INS_SAMPLE_Z)
			|| (ins == sbst_pkg::INS_SAMPLE_PRELOAD);
	endfunction

	function automatic logic sel_id(input logic [2:0] ins);
		sel_id = (ins == sbst_pkg::INS_IDCODE);
	endfunction

	// controller transitions
	always_comb begin
		case (state)
			sbst_pkg::ST_RESET:      next_state = ev.tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_IDLE;
			sbst_pkg::ST_IDLE:       next_state = ev.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
			sbst_pkg::ST_SEL_DR:     next_state = ev.tms ? sbst_pkg::ST_SEL_IR
				: sbst_pkg::ST_CAPTURE_DR;
			sbst_pkg::ST_CAPTURE_DR: next_state = ev.tms ? sbst_pkg::ST_EXIT1_DR
				: sbst_pkg::ST_SHIFT_DR;
			sbst_pkg::ST_SHIFT_DR:   next_state = ev.tms ? sbst_pkg::ST_EXIT1_DR
				: sbst_pkg::ST_SHIFT_DR;
			sbst_pkg::ST_EXIT1_DR:   next_state = ev.tms ? sbst_pkg::ST_UPDATE_DR
				: sbst_pkg::ST_PAUSE_DR;
			sbst_pkg::ST_PAUSE_DR:   next_state = ev.tms ? sbst_pkg::ST_EXIT2_DR
				: sbst_pkg::ST_PAUSE_DR;
			sbst_pkg::ST_EXIT2_DR:   next_state = ev.tms ? sbst_pkg::ST_UPDATE_DR
				: sbst_pkg::ST_SHIFT_DR;
			sbst_pkg::ST_UPDATE_DR:  next_state = ev.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
			sbst_pkg::ST_SEL_IR:     next_state = ev.tms ? sbst_pkg::ST_RESET
				: sbst_pkg::ST_CAPTURE_IR;
			sbst_pkg::ST_CAPTURE_IR: next_state = ev.tms ? sbst_pkg::ST_EXIT1_IR
				: sbst_pkg::ST_SHIFT_IR;
			sbst_pkg::ST_SHIFT_IR:   next_state = ev.tms ? sbst_pkg::ST_EXIT1_IR
				: sbst_pkg::ST_SHIFT_IR;
			sbst_pkg::ST_EXIT1_IR:   next_state = ev.tms ? sbst_pkg::ST_UPDATE_IR
				: sbst_pkg::ST_PAUSE_IR;
			sbst_pkg::ST_PAUSE_IR:   next_state = ev.tms ? sbst_pkg::ST_EXIT2_IR
				: sbst_pkg::ST_PAUSE_IR;
			sbst_pkg::ST_EXIT2_IR:   next_state = ev.tms ? sbst_pkg::ST_UPDATE_IR
				: sbst_pkg::ST_SHIFT_IR;
			sbst_pkg::ST_UPDATE_IR:  next_state = ev.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
			default:                 next_state = sbst_pkg::ST_RESET;
		endcase
	end

	// state moves only on a test clock rise
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			state <= sbst_pkg::ST_RESET;
		end else if (ev.rise) begin
			state <= next_state;
		end
	end

	// instruction shift and active registers
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			ir_shift  <= sbst_pkg::IR_RESET_VALUE;
			ir_active <= sbst_pkg::IR_RESET_VALUE;
		end else if (ev.rise) begin
			case (state)
				sbst_pkg::ST_RESET: begin
					ir_active <= sbst_pkg::IR_RESET_VALUE;
				end
				sbst_pkg::ST_CAPTURE_IR: begin
					ir_shift <= {ir_active[2], sbst_pkg::IR_CAPTURE_LOW};
				end
				sbst_pkg::ST_SHIFT_IR: begin
					ir_shift <= {ev.tdi, ir_shift[2:1]};
				end
				sbst_pkg::ST_UPDATE_IR: begin
					ir_active <= ir_shift;
				end
				default: begin
					ir_active <= ir_active;
				end
			endcase
		end
	end

	// data registers: capture and shift
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			bypass_ff <= 1'h0;
			bsr       <= '1;
			id_reg    <= 32'h0000_0000;
		end else if (ev.rise) begin
			if (state == sbst_pkg::ST_CAPTURE_DR) begin
				bypass_ff <= 1'h0;
				if (sel_bsr(ir_active))
					bsr <= {{BSR_SPARE{1'h1}}, pin_sync};
				if (sel_id(ir_active))
					id_reg <= ID_CODE;
			end else if (state == sbst_pkg::ST_SHIFT_DR) begin
				if (sel_bsr(ir_active))
					bsr <= {ev.tdi, bsr[BSR_LEN-1:1]};
				else if (sel_id(ir_active))
					id_reg <= {ev.tdi, id_reg[31:1]};
				else
					bypass_ff <= ev.tdi;
			end
		end
	end

	// one register feeds the serial output
	always_comb begin
		if (state == sbst_pkg::ST_SHIFT_IR)
			serial_bit = ir_shift[0];
		else if (sel_bsr(ir_active))
			serial_bit = bsr[0];
		else if (sel_id(ir_active))
			serial_bit = id_reg[0];
		else
			serial_bit = bypass_ff;
		next_oe = (state == sbst_pkg::ST_SHIFT_IR) || (state == sbst_pkg::ST_SHIFT_DR);
	end

	// serial output updates on a falling test clock edge only
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			TDO_O    <= 1'h0;
			TDO_OE_O <= 1'h0;
		end else if (ev.fall) begin
			TDO_O    <= next_oe ? serial_bit : 1'h0;
			TDO_OE_O <= next_oe;
		end
	end

	// memory-side controls follow the active instruction; drive levels follow the boundary register
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			OUTPUTS_FLOAT_O <= 1'h0;
			EXTEST_DRIVE_O  <= 1'h0;
			EXTEST_LEVEL_O  <= '0;
			INSTRUCTION_O   <= sbst_pkg::IR_RESET_VALUE;
		end else begin
			OUTPUTS_FLOAT_O <= (ir_active == sbst_pkg::INS_SAMPLE_Z);
			EXTEST_DRIVE_O  <= (ir_active == sbst_pkg::INS_EXTEST);
			EXTEST_LEVEL_O  <= bsr[BSR_PINS-1:0];
			INSTRUCTION_O   <= ir_active;
		end
	end

	// assertions
	localparam logic [2:0] TMS_LIMIT = 3'(sbst_pkg::RESET_TMS_EDGES);
	logic [2:0] tms_high_count;
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I)
			tms_high_count <= 3'h0;
		else if (ev.rise)
			tms_high_count <= !ev.tms ? 3'h0
				: (tms_high_count == TMS_LIMIT) ? TMS_LIMIT : tms_high_count + 3'h1;
	end

	a_five_tms_reset: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(tms_high_count == TMS_LIMIT) |-> (state == sbst_pkg::ST_RESET))
		else $error("five tms highs did not reach reset");
	a_tdo_fall_only: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		!$past(ev.fall) |-> ($stable(TDO_OE_O) && $stable(TDO_O)))
		else $error("tdo changed off a falling edge");
	a_tdo_oe_shift: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		ev.fall |=> (TDO_OE_O == ($past(state) == sbst_pkg::ST_SHIFT_IR
			|| $past(state) == sbst_pkg::ST_SHIFT_DR)))
		else $error("tdo enable wrong after falling edge");
	a_ir_capture_low: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ev.rise && state == sbst_pkg::ST_CAPTURE_IR) |=> (ir_shift[1:0] == 2'h1))
		else $error("capture-ir pattern wrong");
	a_ir_reset_load: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ev.rise && state == sbst_pkg::ST_RESET) |=> (ir_active == sbst_pkg::INS_IDCODE))
		else $error("instruction not reset to id");
	a_ir_hold: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		!(ev.rise && (state == sbst_pkg::ST_UPDATE_IR || state == sbst_pkg::ST_RESET))
			|=> $stable(ir_active))
		else $error("instruction changed outside update");
	a_id_capture: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ev.rise && state == sbst_pkg::ST_CAPTURE_DR && ir_active == sbst_pkg::INS_IDCODE)
			|=> (id_reg == ID_CODE))
		else $error("id code not captured");
	a_bypass_shift: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ev.rise && state == sbst_pkg::ST_SHIFT_DR && ir_active == sbst_pkg::INS_BYPASS)
			|=> (bypass_ff == $past(ev.tdi)))
		else $error("bypass did not take serial input");
	a_spare_ones: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ev.rise && state == sbst_pkg::ST_CAPTURE_DR && sel_bsr(ir_active))
			|=> (bsr[BSR_LEN-1:BSR_PINS] == '1))
		else $error("spare boundary bits not one");
	a_float_sample_z: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ir_active == sbst_pkg::INS_SAMPLE_Z) |=> OUTPUTS_FLOAT_O)
		else $error("outputs not floated");
	a_ir_shift_in: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ev.rise && state == sbst_pkg::ST_SHIFT_IR) |=> (ir_shift[2] == $past(ev.tdi)))
		else $error("instruction did not take serial input");
	a_state_onehot: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		$onehot(state))
		else $error("controller state not one-hot");
	a_tdo_quiet: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		!TDO_OE_O |-> !TDO_O)
		else $error("tdo high while disabled");
	a_bsr_capture: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ev.rise && state == sbst_pkg::ST_CAPTURE_DR && sel_bsr(ir_active))
			|=> (bsr[BSR_PINS-1:0] == $past(pin_sync)))
		else $error("boundary capture missed pin levels");
	a_extest_drive: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ir_active == sbst_pkg::INS_EXTEST) |=> EXTEST_DRIVE_O)
		else $error("extest drive not raised");
	a_id_first_bit: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ev.fall && state == sbst_pkg::ST_SHIFT_DR && sel_id(ir_active))
			|=> (TDO_O == $past(id_reg[0])))
		else $error("id register bit 0 not on serial output");

	// covers
	c_pause_dr: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		ev.rise && state == sbst_pkg::ST_PAUSE_DR);

	c_id_shift: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		state == sbst_pkg::ST_SHIFT_DR && ir_active == sbst_pkg::INS_IDCODE);
	c_update_ir: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		ev.rise && state == sbst_pkg::ST_UPDATE_IR);
	c_sample_z: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I) OUTPUTS_FLOAT_O);
	c_bypass: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		state == sbst_pkg::ST_SHIFT_DR && ir_active == sbst_pkg::INS_BYPASS);
endmodule // sbst_tap
`default_nettype wire

// ### sbst_ctl_model.sv
// partner model: board scan controller driving the test pins
`timescale 1ns/100ps
`default_nettype none
module sbst_ctl_model (
	input  wire logic       clock_i,
	input  wire logic       tdo_i,
	input  wire logic       tdo_oe_i,
	output logic            tck_o,
	output logic            tms_o,
	output logic            tdi_o,
	output logic            seen_o,
	output logic [1:0]      seen_val_o
);
	// pins released: pull-ups give one, test clock stands still
	initial begin
		tck_o = 1'b1;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		seen_o = 1'b0;
		seen_val_o = 2'h0;
	end
	// one 400 ns test clock period: fall, 4 cycles low, rise, 4 cycles high
	// called on a rising clock edge, returns on one
	task automatic step(input logic tms, input logic tdi);
		tck_o <= 1'b0;
		tms_o <= tms;
		tdi_o <= tdi;
		repeat (4) @(posedge clock_i);
		tck_o <= 1'b1;
		repeat (3) @(posedge clock_i);
		seen_o <= 1'b1;
		seen_val_o <= {tdo_oe_i, tdo_i};
		tms_o <= 1'b1;
		tdi_o <= 1'b1;
		@(posedge clock_i);
		seen_o <= 1'b0;
	endtask
endmodule // sbst_ctl_model
`default_nettype wire

// ### sbst_tap_bench.sv
// testbench for the boundary scan test access port
`timescale 1ns/100ps
`default_nettype none
module sbst_tap_bench;
	localparam int          PINS   = 8;
	localparam int          SPARE  = 2;
	// arbitrary identification value
	localparam logic [31:0] ID_VAL = 32'h1357_9BDF;
	logic              clock = 1'b0;
	logic              reset_n = 1'b0;
	logic              tck;
	logic              tms;
	logic              tdi;
	logic [PINS-1:0]   pin_level = '0;
	logic              tdo;
	logic              tdo_oe;
	logic              float_out;
	logic              drive;
	logic [PINS-1:0]   level;
	logic [2:0]        instr;
	logic              seen;
	logic [1:0]        seen_val;
	logic [1:0]        notes[$];
	int                num_errors = 0;
	int                check_count = 0;
	int                seed;
	always #25 clock = ~clock;
	sbst_tap #(.BSR_PINS(PINS), .BSR_SPARE(SPARE), .ID_CODE(ID_VAL)) dut (
		.CLOCK_I(clock), .RESET_N_I(reset_n), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
		.PIN_LEVEL_I(pin_level), .TDO_O(tdo), .TDO_OE_O(tdo_oe),
		.OUTPUTS_FLOAT_O(float_out), .EXTEST_DRIVE_O(drive),
		.EXTEST_LEVEL_O(level), .INSTRUCTION_O(instr)
	);
	sbst_ctl_model ctl (
		.clock_i(clock), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
		.tdi_o(tdi), .seen_o(seen), .seen_val_o(seen_val)
	);
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one test clock step with its expected enable and serial output
	task automatic note_step(input logic [1:0] exp, input logic t, input logic d);
		notes.push_back(exp);
		ctl.step(t, d);
	endtask
	// full register scan from idle back to idle
	task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
		input logic [31:0] exp, input logic [2:0] ins_now);
		int i;
		note_step(2'h0, 1'b1, 1'b1);
		if (is_ir) begin
			note_step(2'h0, 1'b1, 1'b1);
		end
		note_step(2'h0, 1'b0, 1'b1);
		note_step(2'h0, 1'b0, 1'b1);
		for (i = 0; i < n; i++) begin
			note_step({1'b1, exp[i]}, i == n - 1 || i == n / 2, din[i]);
			if (i == n / 2) begin
				note_step(2'h0, 1'b0, 1'b1);
				note_step(2'h0, 1'b1, 1'b1);
				note_step(2'h0, 1'b0, 1'b1);
			end
		end
		check("held_instruction", {29'h0, ins_now}, {29'h0, instr});
		note_step(2'h0, 1'b1, 1'b1);
		note_step(2'h0, 1'b0, 1'b1);
	endtask
	// result watcher: oldest note against what the controller saw
	always @(posedge clock) begin
		if (seen === 1'b1) begin
			if (notes.size() == 0) begin
				num_errors++;
				$display("BAD tdo_stream expected note seen none");
			end else begin
				check("tdo_stream", {30'h0, notes.pop_front()}, {30'h0, seen_val});
			end
		end
	end
	initial begin
		#2000000;
		num_errors++;
		$display("BAD watchdog expected done seen hang");
		conclude();
	end
	initial begin
		logic [31:0] din;
		logic [31:0] exp;
		int          code;
		int          n;
		seed = 19714;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (40) @(posedge clock);
		check("reset_instruction", 32'h1, {29'h0, instr});
		check("idle_enable", 32'h0, {31'h0, tdo_oe});
		note_step(2'h0, 1'b0, 1'b1);
		din = $random(seed);
		scan(1'b0, 32, din, ID_VAL, sbst_pkg::INS_IDCODE);
		for (code = 0; code < 8; code++) begin
			pin_level <= PINS'($random(seed));
			din = $random(seed);
			scan(1'b1, 3, 32'(code), 32'h1, sbst_pkg::INS_IDCODE);
			repeat (2) @(posedge clock);
			check("instruction", 32'(code), {29'h0, instr});
			check("float", {31'h0, code == 2}, {31'h0, float_out});
			check("extest_drive", {31'h0, code == 0}, {31'h0, drive});
			if (code == 0 || code == 2 || code == 4) begin
				n = PINS + SPARE;
				exp = '1;
				exp[PINS-1:0] = pin_level;
			end else if (code == 1) begin
				n = 32;
				exp = ID_VAL;
			end else begin
				n = 8;
				exp = {din[30:0], 1'b0};
			end
			scan(1'b0, n, din, exp, code[2:0]);
			if (code == 0) begin
				check("extest_level", {24'h0, din[PINS-1:0]}, {24'h0, level});
			end
			repeat (5) note_step(2'h0, 1'b1, 1'b1);
			repeat (3) @(posedge clock);
			check("tms_reset", 32'h1, {29'h0, instr});
			note_step(2'h0, 1'b0, 1'b1);
		end
		repeat (4) @(posedge clock);
		check("notes_left", 32'h0, notes.size());
		conclude();
	end
endmodule // sbst_tap_bench
`default_nettype wire
